// [inc/ocp_pkg.sv]
// constants for the overcurrent fault and hiccup controller
package ocp_pkg;

  // ==========================================
  // clock and timing
  localparam int unsigned CLK_FREQ_HZ    = 25000000;
  localparam int unsigned BLANK_TIME_NS  = 125;
  // longest time: round down, at least one cycle
  localparam int unsigned BLANK_CYC_RAW  = (BLANK_TIME_NS * (CLK_FREQ_HZ / 1000000)) / 1000;
  localparam int unsigned BLANK_CYCLES   = (BLANK_CYC_RAW < 1) ? 1 : BLANK_CYC_RAW;

  // ==========================================
  // fault counter
  localparam int unsigned FAULT_CNT_W    = 3;
  localparam logic [2:0]  FAULT_LIMIT    = 3'h7;
  localparam logic [2:0]  FAULT_CNT_RST  = 3'h0;

  // ==========================================
  // register map (byte addresses)
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK  = 4'hc;

  // ctrl fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam logic [31:0] CTRL_RST_VAL   = 32'h0000_0000;

  // status fields
  localparam int unsigned ST_CNT_LSB     = 0;
  localparam int unsigned ST_FAULT_BIT   = 3;
  localparam int unsigned ST_BLANK_BIT   = 4;
  localparam int unsigned ST_REGMODE_BIT = 5;
  localparam int unsigned ST_FIRST_BIT   = 6;

  // interrupt event bits
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_OC_BIT     = 0;
  localparam int unsigned IRQ_FAULT_BIT  = 1;
  localparam int unsigned IRQ_RESTART_BIT = 2;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

  typedef enum logic [1:0] {
    OCP_RUN,
    OCP_HICCUP
  } ocp_mode_e;

endpackage

// [src/ocp_blank_timer.sv]
// blanking window timer for the current-limit threshold node
`timescale 1ns/1ps
module ocp_blank_timer
  import ocp_pkg::*;
#(
  parameter int unsigned CYCLES = BLANK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic start_i,
  input  wire logic sw_high_i,
  // status
  output logic      blank_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CLAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;

  // ==========================================
  // window opens on start, closes on switch node high or timeout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_o <= 1'b0;
      cnt_reg <= '0;
    end else if (start_i) begin
      blank_o <= 1'b1;
      cnt_reg <= '0;
    end else if (blank_o) begin
      if (sw_high_i) begin
        blank_o <= 1'b0;
      end else if (cnt_reg == CLAST) begin
        blank_o <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + CW'(1);
      end
    end
  end

  // ==========================================
  // checks
  property p_blank_timeout;
    @(posedge clk_i) disable iff (rst_i)
      $rose(blank_o) && !start_i |-> ##[1:CYCLES] !blank_o || start_i;
  endproperty
  a_blank_timeout: assert property (p_blank_timeout) else $error("blank window too long");

  property p_blank_swhigh;
    @(posedge clk_i) disable iff (rst_i)
      blank_o && sw_high_i && !start_i |=> !blank_o;
  endproperty
  a_blank_swhigh: assert property (p_blank_swhigh) else $error("blank not ended by sw");

endmodule

// [src/ocp_ctrl.sv]
// overcurrent fault and hiccup controller with wishbone registers
`timescale 1ns/1ps
module ocp_ctrl
  import ocp_pkg::*;
#(
  parameter int unsigned BLANK_CYC = BLANK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // analog and oscillator inputs (asynchronous)
  input  wire logic        cycle_start_i,
  input  wire logic        pwm_i,
  input  wire logic        oc_trip_i,
  input  wire logic        switch_node_high_i,
  input  wire logic        ss_cycle_done_i,
  input  wire logic        vdd_below_8v5_i,
  input  wire logic        vdd_above_10v_i,
  input  wire logic        pg_ok_i,
  // outputs
  output logic             high_side_gate_drive_o,
  output logic             low_side_gate_drive_o,
  output logic             current_limit_threshold_node_pull_o,
  output logic             driver_bias_rail_ldo_o,
  output logic             power_good_output_o,
  output logic             irq_o
);

  // ==========================================
  // input synchronisers
  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] sync3_reg;

  assign raw_in = {pg_ok_i, vdd_above_10v_i, vdd_below_8v5_i, ss_cycle_done_i,
                   switch_node_high_i, oc_trip_i, pwm_i, cycle_start_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic cyc_edge;
  logic ss_edge;
  logic pwm_s;
  logic oc_s;
  logic swh_s;
  logic lo8_s;
  logic hi10_s;
  logic pgok_s;

  assign cyc_edge = sync2_reg[0] & ~sync3_reg[0];
  assign pwm_s    = sync2_reg[1];
  assign oc_s     = sync2_reg[2];
  assign swh_s    = sync2_reg[3];
  assign ss_edge  = sync2_reg[4] & ~sync3_reg[4];
  assign lo8_s    = sync2_reg[5];
  assign hi10_s   = sync2_reg[6];
  assign pgok_s   = sync2_reg[7];

  // ==========================================
  // control state
  ocp_mode_e        mode_reg;
  logic [2:0]       fcnt_reg;
  logic             en_reg;
  logic             hs_on_reg;
  logic             term_reg;
  logic             oc_seen_reg;
  logic             first_reg;
  logic             blank;
  logic             blank_start;
  logic             oc_valid;
  logic             run;

  assign run = (mode_reg == OCP_RUN) && en_reg;
  // open the blanking window on the cycle edge, one clock before turn-on
  assign blank_start = run && cyc_edge;
  assign oc_valid = oc_s && hs_on_reg && !blank && run;

  ocp_blank_timer #(
    .CYCLES (BLANK_CYC)
  ) u_blank (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (blank_start),
    .sw_high_i (swh_s),
    .blank_o   (blank)
  );

  // ==========================================
  // high-side pulse: on after the window opens, ends on pwm low or trip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_on_reg <= 1'b0;
      term_reg  <= 1'b0;
    end else if (!run) begin
      hs_on_reg <= 1'b0;
      term_reg  <= 1'b0;
    end else if (cyc_edge) begin
      hs_on_reg <= 1'b0;
      term_reg  <= 1'b0;
    end else if (oc_valid) begin
      hs_on_reg <= 1'b0;
      term_reg  <= 1'b1;
    end else if (!term_reg && pwm_s && blank) begin
      hs_on_reg <= 1'b1;
    end else if (!pwm_s) begin
      hs_on_reg <= 1'b0;
    end
  end

  // ==========================================
  // gate drive outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_side_gate_drive_o <= 1'b0;
      low_side_gate_drive_o  <= 1'b0;
      first_reg              <= 1'b0;
    end else if (!run || fault_ev) begin
      // drives drop on the edge that declares the fault, not one clock later
      high_side_gate_drive_o <= 1'b0;
      low_side_gate_drive_o  <= 1'b0;
      first_reg              <= 1'b0;
    end else begin
      high_side_gate_drive_o <= hs_on_reg && !oc_valid;
      if (hs_on_reg) begin
        first_reg <= 1'b1;
      end
      low_side_gate_drive_o <= first_reg && !hs_on_reg && !blank;
    end
  end

  // ==========================================
  // per-cycle overcurrent memory
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_seen_reg <= 1'b0;
    end else if (!run || cyc_edge) begin
      oc_seen_reg <= 1'b0;
    end else if (oc_valid) begin
      oc_seen_reg <= 1'b1;
    end
  end

  // ==========================================
  // fault counter and hiccup mode
  logic fault_ev;
  logic restart_ev;
  assign fault_ev   = run && cyc_edge && (oc_seen_reg || oc_valid) &&
                      (fcnt_reg == FAULT_LIMIT - 3'h1);
  assign restart_ev = (mode_reg == OCP_HICCUP) && ss_edge && (fcnt_reg == 3'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= OCP_RUN;
      fcnt_reg <= FAULT_CNT_RST;
    end else begin
      case (mode_reg)
        OCP_RUN: begin
          if (run && cyc_edge) begin
            if (oc_seen_reg || oc_valid) begin
              fcnt_reg <= fcnt_reg + 3'h1;
              if (fault_ev) begin
                mode_reg <= OCP_HICCUP;
              end
            end else if (fcnt_reg != 3'h0) begin
              fcnt_reg <= fcnt_reg - 3'h1;
            end
          end
        end
        OCP_HICCUP: begin
          if (ss_edge) begin
            fcnt_reg <= fcnt_reg - 3'h1;
            if (restart_ev) begin
              mode_reg <= OCP_RUN;
            end
          end
        end
        default: begin
          mode_reg <= OCP_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // regulator mode, threshold pull and power good
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      driver_bias_rail_ldo_o <= 1'b1;
    end else if (lo8_s) begin
      driver_bias_rail_ldo_o <= 1'b1;
    end else if (hi10_s) begin
      driver_bias_rail_ldo_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_limit_threshold_node_pull_o <= 1'b0;
      power_good_output_o                 <= 1'b0;
    end else begin
      current_limit_threshold_node_pull_o <= blank_start || (blank && !swh_s);
      power_good_output_o <= pgok_s && run && !oc_valid && !oc_seen_reg;
    end
  end

  // ==========================================
  // interrupts and wishbone registers
  logic [IRQ_W-1:0] ist_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic [IRQ_W-1:0] ev;
  logic             acc;
  logic             rd_ist;

  assign ev     = {restart_ev, fault_ev, oc_valid};
  assign acc    = cyc_i && stb_i && !ack_o;
  assign rd_ist = acc && !we_i && (adr_i == ADDR_IRQ_STAT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o     <= 1'b0;
      dat_o     <= 32'h0000_0000;
      en_reg    <= CTRL_RST_VAL[CTRL_EN_BIT];
      imask_reg <= IRQ_MASK_RST;
    end else begin
      ack_o <= acc;
      if (acc && we_i && sel_i[0]) begin
        if (adr_i == ADDR_CTRL) begin
          en_reg <= dat_i[CTRL_EN_BIT];
        end
        if (adr_i == ADDR_IRQ_MASK) begin
          imask_reg <= dat_i[IRQ_W-1:0];
        end
      end
      dat_o <= 32'h0000_0000;
      if (acc && !we_i) begin
        case (adr_i)
          ADDR_CTRL:     dat_o[CTRL_EN_BIT] <= en_reg;
          ADDR_STATUS: begin
            dat_o[ST_CNT_LSB +: FAULT_CNT_W] <= fcnt_reg;
            dat_o[ST_FAULT_BIT]   <= (mode_reg == OCP_HICCUP);
            dat_o[ST_BLANK_BIT]   <= blank;
            dat_o[ST_REGMODE_BIT] <= driver_bias_rail_ldo_o;
            dat_o[ST_FIRST_BIT]   <= first_reg;
          end
          ADDR_IRQ_STAT: dat_o[IRQ_W-1:0] <= ist_reg;
          ADDR_IRQ_MASK: dat_o[IRQ_W-1:0] <= imask_reg;
          default:       dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // read clears; a new event in that cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_reg <= '0;
      irq_o   <= 1'b0;
    end else begin
      ist_reg <= (rd_ist ? '0 : ist_reg) | ev;
      irq_o   <= |(((rd_ist ? '0 : ist_reg) | ev) & imask_reg);
    end
  end

  // ==========================================
  // checks
  property p_oc_ends_pulse;
    @(posedge clk_i) disable iff (rst_i)
      oc_valid |=> !high_side_gate_drive_o;
  endproperty
  a_oc_ends_pulse: assert property (p_oc_ends_pulse) else $error("pulse not ended");

  property p_stay_off;
    @(posedge clk_i) disable iff (rst_i)
      term_reg && !cyc_edge |=> !hs_on_reg;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("high side back on");

  property p_no_oc_in_blank;
    @(posedge clk_i) disable iff (rst_i)
      blank && !term_reg && !oc_seen_reg |=> !term_reg && !oc_seen_reg;
  endproperty
  a_no_oc_in_blank: assert property (p_no_oc_in_blank) else $error("oc seen in blank");

  property p_fault_at_seven;
    @(posedge clk_i) disable iff (rst_i)
      fault_ev |=> mode_reg == OCP_HICCUP && fcnt_reg == FAULT_LIMIT;
  endproperty
  a_fault_at_seven: assert property (p_fault_at_seven) else $error("no fault at 7");

  property p_drives_off;
    @(posedge clk_i) disable iff (rst_i)
      mode_reg == OCP_HICCUP && $past(mode_reg) == OCP_HICCUP |->
        !high_side_gate_drive_o && !low_side_gate_drive_o;
  endproperty
  a_drives_off: assert property (p_drives_off) else $error("drive in fault");

  property p_hiccup_dec;
    @(posedge clk_i) disable iff (rst_i)
      mode_reg == OCP_HICCUP && ss_edge |=> fcnt_reg == $past(fcnt_reg) - 3'h1;
  endproperty
  a_hiccup_dec: assert property (p_hiccup_dec) else $error("no hiccup decrement");

  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
      restart_ev |=> mode_reg == OCP_RUN && fcnt_reg == 3'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart at zero");

  property p_sat_zero;
    @(posedge clk_i) disable iff (rst_i)
      mode_reg == OCP_RUN && fcnt_reg == 3'h0 && cyc_edge && !oc_seen_reg && !oc_valid
        |=> fcnt_reg == 3'h0;
  endproperty
  a_sat_zero: assert property (p_sat_zero) else $error("counter wrapped");

  property p_ls_first;
    @(posedge clk_i) disable iff (rst_i)
      !first_reg |=> !low_side_gate_drive_o;
  endproperty
  a_ls_first: assert property (p_ls_first) else $error("low side early");

  property p_pg_oc;
    @(posedge clk_i) disable iff (rst_i)
      oc_valid |=> !power_good_output_o;
  endproperty
  a_pg_oc: assert property (p_pg_oc) else $error("power good during oc");

  property p_reg_mode;
    @(posedge clk_i) disable iff (rst_i)
      lo8_s |=> driver_bias_rail_ldo_o;
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("regulator mode wrong");

endmodule

// [bench/ocp_analog_model.sv]
// oscillator, overcurrent comparator and switch-node sensor model
`timescale 1ns/1ps
module ocp_analog_model #(
  parameter int unsigned PERIOD  = 40,
  parameter int unsigned ON_TIME = 20,
  parameter int unsigned SS_TIME = 20
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // gate drive and fault setup
  input  wire logic hs_drive_i,
  input  wire logic short_i,
  input  wire logic sw_stuck_i,
  // comparator and oscillator outputs
  output logic      cycle_start_o,
  output logic      pwm_o,
  output logic      oc_trip_o,
  output logic      sw_high_o,
  output logic      ss_done_o
);
  int unsigned phase    = 0;
  int unsigned ss_phase = 0;

  initial begin
    cycle_start_o = 1'b0;
    pwm_o = 1'b0;
    ss_done_o = 1'b0;
  end

  // both comparators follow the high-side drive; the switch node rises only while it drives and is not stuck
  assign sw_high_o = hs_drive_i & ~sw_stuck_i;
  assign oc_trip_o = hs_drive_i & short_i;

  always @(posedge clk_i) begin
    phase <= (rst_i || phase == PERIOD - 1) ? 0 : phase + 1;
    ss_phase <= (rst_i || ss_phase == SS_TIME - 1) ? 0 : ss_phase + 1;
    cycle_start_o <= !rst_i && phase < 2;
    pwm_o <= !rst_i && phase < ON_TIME;
    ss_done_o <= !rst_i && ss_phase < 2;
  end
endmodule

// [bench/testbench.sv]
// self-checking bench for the overcurrent fault and hiccup controller
`timescale 1ns/1ps
module testbench;
  import ocp_pkg::*;
  // longer blanking so a switch-node end is seen before the timeout
  localparam int unsigned BLANK_N = 8;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd, acc;
  logic        ack_o, cs, pwm, trip, swh, ssd, hs, ls, pull, ldo, pgood, irq_o;
  logic        below = 1'b0, above = 1'b0, short_mode = 1'b0, sw_stuck = 1'b0;
  logic        hs_q = 1'b0, cs_q = 1'b0, ended = 1'b0, ls_seen = 1'b0, pg_low = 1'b0;
  logic        drv_bad;
  int          errors = 0, samples_checked = 0, cycles = 0, n_cs = 0, cs0;
  int          hs_len = 0, pull_len = 0, last_hs = 0, last_pull = 0;

  always #20 clk_i = ~clk_i;

  ocp_ctrl #(.BLANK_CYC(BLANK_N)) u_ocp_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cycle_start_i(cs), .pwm_i(pwm), .oc_trip_i(trip), .switch_node_high_i(swh),
    .ss_cycle_done_i(ssd), .vdd_below_8v5_i(below), .vdd_above_10v_i(above),
    .pg_ok_i(1'b1), .high_side_gate_drive_o(hs), .low_side_gate_drive_o(ls),
    .current_limit_threshold_node_pull_o(pull), .driver_bias_rail_ldo_o(ldo),
    .power_good_output_o(pgood), .irq_o(irq_o));

  ocp_analog_model u_ocp_analog_model (
    .clk_i(clk_i), .rst_i(rst_i), .hs_drive_i(hs), .short_i(short_mode),
    .sw_stuck_i(sw_stuck), .cycle_start_o(cs), .pwm_o(pwm), .oc_trip_o(trip),
    .sw_high_o(swh), .ss_done_o(ssd));

  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one classic single cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    @(posedge clk_i);
    // only the bench cycle limit ends this wait
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
    chk("ack_drop", 0, ack_o);
  endtask

  // read a register until a bit has been seen set
  task automatic poll(input logic [3:0] a, input int b);
    int n;
    n = 0;
    acc = 32'h0;
    while (acc[b] !== 1'b1 && n < 400) begin
      wb(1'b0, a, 32'h0);
      acc = acc | rd;
      n++;
    end
    if (n == 400) chk("poll", 1, 0);
  endtask

  task automatic hold_vdd(input logic b, input logic t, input logic exp);
    below <= b;
    above <= t;
    repeat (8) @(posedge clk_i);
    chk("ldo_mode", exp, ldo);
  endtask

  // ===========================================
  // port monitors
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      finish_test();
    end
    hs_q <= hs;
    cs_q <= cs;
    hs_len <= hs ? hs_len + 1 : 0;
    pull_len <= pull ? pull_len + 1 : 0;
    if (hs_q && !hs) last_hs <= hs_len;
    if (pull_len > 0 && !pull) last_pull <= pull_len;
    if (ls) ls_seen <= 1'b1;
    if (short_mode && !pgood) pg_low <= 1'b1;
    if (cs && !cs_q) n_cs++;
    if (cs && !cs_q) ended <= 1'b0;
    else if (hs_q && !hs && pwm) ended <= 1'b1;
    if (!hs_q && hs && ended) chk("hs_reon", 0, 1);
  end

  // ===========================================
  // scenarios
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("ldo_rst", 1, ldo);
    chk("hs_rst", 0, hs);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    wb(1'b1, 4'h1, 32'hffff_ffff);
    wb(1'b0, 4'h1, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, ADDR_CTRL, 32'h1);
    repeat (200) @(posedge clk_i);
    chk("ls_after_first", 1, ls_seen);
    chk("blank_sw_end", 1, last_pull > 0 && last_pull < BLANK_N);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("count_clean", 32'h0, rd & 32'h0f);
    chk("first_seen", 1, rd[ST_FIRST_BIT]);
    chk("pg_clean", 1, pgood);
    sw_stuck <= 1'b1;
    repeat (120) @(posedge clk_i);
    // pull rises with the window and drops one clock after the timer closes it
    chk("blank_timeout", BLANK_N + 1, last_pull);
    for (int i = 0; i < 50 && cs !== 1'b1; i++) @(posedge clk_i);
    @(posedge clk_i);
    short_mode <= 1'b1;
    cs0 = n_cs;
    poll(ADDR_STATUS, ST_FAULT_BIT);
    chk("fault_cycles", 7, n_cs - cs0);
    chk("hs_trip_len", 1, last_hs + 3 >= BLANK_N && last_hs <= BLANK_N + 4);
    chk("pg_trip", 1, pg_low);
    chk("irq_masked", 0, irq_o);
    wb(1'b1, ADDR_IRQ_MASK, 32'h7);
    @(posedge clk_i);
    chk("irq_unmasked", 1, irq_o);
    drv_bad = 1'b0;
    repeat (60) begin
      @(posedge clk_i);
      if (hs !== 1'b0 || ls !== 1'b0) drv_bad = 1'b1;
    end
    chk("hiccup_drive", 0, drv_bad);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("hiccup_bit", 1, rd[ST_FAULT_BIT]);
    chk("hiccup_down", 1, rd[2:0] < 3'h7);
    poll(ADDR_IRQ_STAT, IRQ_RESTART_BIT);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("restart_run", 0, rd[ST_FAULT_BIT]);
    cs0 = n_cs;
    poll(ADDR_IRQ_STAT, IRQ_FAULT_BIT);
    chk("refault", 1, (n_cs - cs0) >= 6 && (n_cs - cs0) <= 8);
    hold_vdd(1'b0, 1'b1, 1'b0);
    hold_vdd(1'b0, 1'b0, 1'b0);
    hold_vdd(1'b1, 1'b0, 1'b1);
    hold_vdd(1'b0, 1'b0, 1'b1);
    finish_test();
  end
endmodule
